// *** core/adc_fmt_ctrl.sv ***
// converter digital back end: correction, pipeline, coding, three-state, bus
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module adc_fmt_ctrl
   import adc_fmt_pkg::*;
#(
   parameter int DEPTH = PIPE_DEPTH
)(
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire logic [COARSE_W-1:0] COARSE_CODE,
   input  wire logic [FINE_W-1:0]   FINE_CODE,
   input  wire logic                ABOVE_TOP_REF,
   input  wire logic                BELOW_BOTTOM_REF,
   output logic [RES_W-1:0]         RESULT_WORD,
   output logic                     OVER_FLAG,
   output logic                     UNDER_FLAG,
   output logic                     RESULT_OE_N,
   output logic                     POWER_SAVE,
   output logic                     IRQ,
   input  wire logic                WB_CYC_I,
   input  wire logic                WB_STB_I,
   input  wire logic                WB_WE_I,
   input  wire logic [3:0]          WB_ADR_I,
   input  wire logic [3:0]          WB_SEL_I,
   input  wire logic [31:0]         WB_DAT_I,
   output logic [31:0]              WB_DAT_O,
   output logic                     WB_ACK_O
);
   localparam int PW = RES_W + 2;

   // front end latches
   logic [COARSE_W-1:0] coarse_ff;
   logic [COARSE_W-1:0] nxt_coarse;
   logic                over_in_ff;
   logic                under_in_ff;
   logic                nxt_over_in;
   logic                nxt_under_in;
   logic [FINE_W-1:0]   fine_ff;
   logic [FINE_W-1:0]   nxt_fine;
   logic [SUM_W-1:0]    sum;
   logic [RES_W-1:0]    corr_val;

   // pipeline and outputs
   logic [PW-1:0]       pipe_ff [DEPTH];
   logic [PW-1:0]       nxt_pipe [DEPTH];
   logic [RES_W-1:0]    raw_ff;
   logic [RES_W-1:0]    nxt_raw;
   logic [1:0]          pol_ff;
   logic [1:0]          nxt_pol;
   logic [RES_W-1:0]    word_ff;
   logic [RES_W-1:0]    nxt_word;
   logic                over_ff;
   logic                under_ff;
   logic                nxt_over;
   logic                nxt_under;
   logic                oe_n_ff;
   logic                nxt_oe_n;
   logic                ps_ff;
   logic                nxt_ps;

   // register file
   logic [3:0]          ctrl_ff;
   logic [3:0]          nxt_ctrl;
   logic [1:0]          stat_ff;
   logic [1:0]          nxt_stat;
   logic [1:0]          mask_ff;
   logic [1:0]          nxt_mask;
   logic                irq_ff;
   logic                nxt_irq;
   logic                ack_ff;
   logic                nxt_ack;
   logic [31:0]         dat_ff;
   logic [31:0]         nxt_dat;
   logic                req;
   logic                wr;
   logic                run;
   logic [1:0]          ev;

   assign RESULT_WORD = word_ff;
   assign OVER_FLAG   = over_ff;
   assign UNDER_FLAG  = under_ff;
   assign RESULT_OE_N = oe_n_ff;
   assign POWER_SAVE  = ps_ff;
   assign IRQ         = irq_ff;
   assign WB_DAT_O    = dat_ff;
   assign WB_ACK_O    = ack_ff;

   assign run = ~ctrl_ff[CTRL_PS];
   assign req = WB_CYC_I & WB_STB_I & ~ack_ff;
   assign wr  = WB_CYC_I & WB_STB_I & ack_ff & WB_WE_I & WB_SEL_I[0]; // lands on the ack edge

   // coarse step and range comparators on the rising edge
   always_comb begin
      nxt_coarse   = run ? COARSE_CODE : coarse_ff;
      nxt_over_in  = run ? ABOVE_TOP_REF : over_in_ff;
      nxt_under_in = run ? BELOW_BOTTOM_REF : under_in_ff;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         coarse_ff   <= '0;
         over_in_ff  <= 1'b0;
         under_in_ff <= 1'b0;
      end else begin
         coarse_ff   <= nxt_coarse;
         over_in_ff  <= nxt_over_in;
         under_in_ff <= nxt_under_in;
      end
   end

   // fine step on the following falling edge
   always_comb begin
      nxt_fine = run ? FINE_CODE : fine_ff;
   end

   always_ff @(negedge CLK) begin
      if (!RST_N) begin
         fine_ff <= '0;
      end else begin
         fine_ff <= nxt_fine;
      end
   end

   // digital correction: fine step overlaps coarse by 16 codes each side
   always_comb begin
      sum = {coarse_ff, 6'h00} >> 1;
      sum = sum + {5'h00, fine_ff};
      if (sum < FINE_OFFSET) begin
         corr_val = '0;
      end else if (sum - FINE_OFFSET > RES_MAX) begin
         corr_val = RES_MAX[RES_W-1:0];
      end else begin
         corr_val = RES_W'(sum - FINE_OFFSET);
      end
   end

   // fixed latency pipeline, one sample per clock
   always_comb begin
      nxt_pipe[0] = run ? {under_in_ff, over_in_ff, corr_val} : pipe_ff[0];
      for (int i = 1; i < DEPTH; i++) begin
         nxt_pipe[i] = run ? pipe_ff[i-1] : pipe_ff[i];
      end
   end

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_pipe
         always_ff @(posedge CLK) begin
            if (!RST_N) begin
               pipe_ff[g] <= '0;
            end else begin
               pipe_ff[g] <= nxt_pipe[g];
            end
         end
      end
   endgenerate

   // output coding and three-state control
   always_comb begin
      nxt_raw   = raw_ff;
      nxt_pol   = pol_ff;
      nxt_word  = word_ff;
      nxt_over  = over_ff;
      nxt_under = under_ff;
      if (run) begin
         nxt_raw   = pipe_ff[DEPTH-1][RES_W-1:0];
         nxt_pol   = {ctrl_ff[CTRL_TOP], ctrl_ff[CTRL_LOWER]};
         nxt_word[RES_W-2:0] = nxt_raw[RES_W-2:0]
                              ^ {(RES_W-1){~ctrl_ff[CTRL_LOWER]}};
         nxt_word[RES_W-1]   = nxt_raw[RES_W-1] ^ ~ctrl_ff[CTRL_TOP];
         nxt_over  = pipe_ff[DEPTH-1][RB_OVER];
         nxt_under = pipe_ff[DEPTH-1][RB_UNDER];
      end
      nxt_oe_n = ctrl_ff[CTRL_OE_N];
      nxt_ps   = ctrl_ff[CTRL_PS] & ctrl_ff[CTRL_OE_N];
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         raw_ff   <= '0;
         pol_ff   <= CTRL_RESET[1:0];
         word_ff  <= '0;
         over_ff  <= 1'b0;
         under_ff <= 1'b0;
         oe_n_ff  <= 1'b1;
         ps_ff    <= 1'b1;
      end else begin
         raw_ff   <= nxt_raw;
         pol_ff   <= nxt_pol;
         word_ff  <= nxt_word;
         over_ff  <= nxt_over;
         under_ff <= nxt_under;
         oe_n_ff  <= nxt_oe_n;
         ps_ff    <= nxt_ps;
      end
   end

   // bus slave, sticky events and interrupt
   always_comb begin
      ev        = {run & pipe_ff[DEPTH-1][RB_UNDER], run & pipe_ff[DEPTH-1][RB_OVER]};
      nxt_ctrl  = ctrl_ff;
      nxt_mask  = mask_ff;
      nxt_stat  = stat_ff;
      nxt_ack   = req;
      nxt_dat   = '0;
      if (wr && WB_ADR_I == CTRL_OFS) begin
         nxt_ctrl = WB_DAT_I[3:0];
      end
      if (wr && WB_ADR_I == MASK_OFS) begin
         nxt_mask = WB_DAT_I[1:0];
      end
      if (wr && WB_ADR_I == STAT_OFS) begin
         nxt_stat = stat_ff & ~WB_DAT_I[1:0];
      end
      nxt_stat = nxt_stat | ev;
      if (req && !WB_WE_I) begin
         unique case (WB_ADR_I)
            CTRL_OFS: nxt_dat = {28'h0000000, ctrl_ff};
            STAT_OFS: nxt_dat = {30'h0, stat_ff};
            MASK_OFS: nxt_dat = {30'h0, mask_ff};
            RES_OFS:  nxt_dat = {19'h0, ps_ff, under_ff, over_ff, raw_ff};
            default:  nxt_dat = '0;
         endcase
      end
      nxt_irq = |(nxt_stat & nxt_mask);
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_ff <= CTRL_RESET;
         stat_ff <= EV_RESET;
         mask_ff <= EV_RESET;
         irq_ff  <= 1'b0;
         ack_ff  <= 1'b0;
         dat_ff  <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         irq_ff  <= nxt_irq;
         ack_ff  <= nxt_ack;
         dat_ff  <= nxt_dat;
      end
   end

   // checks
   logic [3:0] run_cnt;

   always_ff @(posedge CLK) begin
      if (!RST_N || !run) begin
         run_cnt <= '0;
      end else if (run_cnt != 4'hf) begin
         run_cnt <= run_cnt + 4'h1;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   property p_latency;
      (run_cnt >= 4'(DEPTH + 2)) |-> raw_ff == $past(corr_val, DEPTH + 1);
   endproperty
   a_latency: assert property (p_latency) else $error("result latency wrong");

   property p_lower_pol;
      (word_ff[RES_W-2:0] ^ raw_ff[RES_W-2:0]) == {(RES_W-1){~pol_ff[0]}};
   endproperty
   a_lower_pol: assert property (p_lower_pol) else $error("low bits coding");

   property p_top_pol;
      (word_ff[RES_W-1] ^ raw_ff[RES_W-1]) == ~pol_ff[1];
   endproperty
   a_top_pol: assert property (p_top_pol) else $error("top bit coding");

   property p_oe;
      $changed(ctrl_ff[CTRL_OE_N]) |=> RESULT_OE_N == $past(ctrl_ff[CTRL_OE_N]);
   endproperty
   a_oe: assert property (p_oe) else $error("enable not followed");

   property p_freeze;
      !run ##1 !run |-> $stable(word_ff) && $stable(over_ff) && $stable(under_ff);
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs move in save");

   property p_open_reset;
      $past(!RST_N) |-> ctrl_ff == CTRL_RESET && RESULT_OE_N && POWER_SAVE;
   endproperty
   a_open_reset: assert property (p_open_reset) else $error("open state wrong");

   property p_flags;
      run ##1 run |-> OVER_FLAG == $past(pipe_ff[DEPTH-1][RB_OVER])
                   && UNDER_FLAG == $past(pipe_ff[DEPTH-1][RB_UNDER]);
   endproperty
   a_flags: assert property (p_flags) else $error("flag path wrong");

   property p_correct;
      (coarse_ff != 5'h00 && coarse_ff != 5'h1f)
         |-> 11'(corr_val) == {1'b0, coarse_ff, 5'h00} + {5'h00, fine_ff} - FINE_OFFSET;
   endproperty
   a_correct: assert property (p_correct) else $error("correction wrong");

   property p_irq;
      IRQ == |(stat_ff & mask_ff);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

   property p_ack;
      (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer wrong");
endmodule

// *** inc/adc_fmt_pkg.sv ***
// constants for the converter output formatter
// What this block does
// - one 10-bit result per clock, sample rate up to 20 MSPS
// - lower polarity select inverts result bits 0 to 8
// - top polarity select inverts bit 9 on its own
// - polarity selects give binary, two's or one's complement codes
// - result bits driven only while enable is low, else high impedance
// - power-save high freezes the core; with enable also high it enters the reduced-consumption state
// - unconnected control inputs read as high: three-stated and saving
// - result word and flags change on the rising sample clock edge
// - overflow above top reference, underflow below bottom, polarity-free
// - enable three-states the ten result bits only; both flags stay driven
// - coarse latched on rising edge, fine on falling, then corrected
package adc_fmt_pkg;
   localparam int          RES_W         = 10;
   localparam int          COARSE_W      = 5;
   localparam int          FINE_W        = 6;
   localparam int          SUM_W         = 11;
   localparam logic [10:0] FINE_OFFSET   = 11'h010;
   localparam logic [10:0] RES_MAX       = 11'h3ff;
   localparam int          PIPE_DEPTH    = 2;
   localparam int          CLK_NS        = 40;
   localparam int          MAX_RATE_MSPS = 20;
   // word offsets on the register bus
   localparam logic [3:0]  CTRL_OFS      = 4'h0;
   localparam logic [3:0]  STAT_OFS      = 4'h4;
   localparam logic [3:0]  MASK_OFS      = 4'h8;
   localparam logic [3:0]  RES_OFS       = 4'hc;
   // control fields
   localparam int          CTRL_LOWER    = 0;
   localparam int          CTRL_TOP      = 1;
   localparam int          CTRL_OE_N     = 2;
   localparam int          CTRL_PS       = 3;
   localparam logic [3:0]  CTRL_RESET    = 4'hf;
   // status and mask fields
   localparam int          EV_OVER       = 0;
   localparam int          EV_UNDER      = 1;
   localparam logic [1:0]  EV_RESET      = 2'h0;
   // result readback fields
   localparam int          RB_OVER       = 10;
   localparam int          RB_UNDER      = 11;
   localparam int          RB_PS         = 12;
endpackage

// *** tb/capture_model.sv ***
// downstream capture logic: latches sample words while the outputs are enabled
`timescale 1ns/1ps
module capture_model
   import adc_fmt_pkg::*;
(
   input  wire logic             clk,
   input  wire logic [RES_W-1:0] word,
   input  wire logic             oe_n,
   output logic      [RES_W-1:0] word_ff
);
   // pins float while the converter is three-stated
   wire [RES_W-1:0] pins = oe_n ? {RES_W{1'bz}} : word;

   always_ff @(posedge clk) begin
      if (!oe_n) begin
         word_ff <= pins;
      end
   end
endmodule

// *** tb/adc_output_format_control_tb_top.sv ***
// self-checking bench for the converter output formatter
`timescale 1ns/1ps
module adc_output_format_control_tb_top
   import adc_fmt_pkg::*;
;
   logic        clk    = 0;
   logic        rst_n  = 0;
   logic        cyc    = 0;
   logic        stb    = 0;
   logic        we     = 0;
   logic        above  = 0;
   logic        below  = 0;
   logic [3:0]  adr    = 4'h0;
   logic [3:0]  sel    = 4'h0;
   logic [31:0] dat    = 32'h0;
   logic [4:0]  coarse = 5'h0;
   logic [5:0]  fine   = 6'h0;
   logic [31:0] rdat;
   logic [31:0] dat_o;
   logic [9:0]  word;
   logic [9:0]  capt;
   logic        over;
   logic        under;
   logic        oe_n;
   logic        ps_o;
   logic        irq;
   logic        ack;
   int          err_total = 0;
   int          compares  = 0;

   always #20 clk = ~clk;

   adc_fmt_ctrl uut (
      .CLK(clk), .RST_N(rst_n), .COARSE_CODE(coarse), .FINE_CODE(fine),
      .ABOVE_TOP_REF(above), .BELOW_BOTTOM_REF(below), .RESULT_WORD(word),
      .OVER_FLAG(over), .UNDER_FLAG(under), .RESULT_OE_N(oe_n), .POWER_SAVE(ps_o),
      .IRQ(irq), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack)
   );

   capture_model cap (.clk(clk), .word(word), .oe_n(oe_n), .word_ff(capt));

   task test_done;
      if (err_total == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // classic single cycle, held until ack is sampled high
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 16);
      if (ack !== 1'b1) begin
         err_total++;
         $display("MISMATCH %0t bus answer missing", $time);
         test_done();
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
   endtask

   // fine code follows a cycle later, paired with the next coarse latch
   task sample(input logic [4:0] c, input logic [5:0] f);
      coarse <= c;
      @(posedge clk);
      fine   <= f;
      repeat (5) @(posedge clk);
   endtask

   // corrected value, then bit inversion where a select is low
   function automatic logic [9:0] coded(logic [4:0] c, logic [5:0] f, logic [1:0] p);
      int v;
      v = c * 32 + f - 16;
      if (v < 0) v = 0;
      if (v > 1023) v = 1023;
      return 10'(v) ^ {~p[1], {9{~p[0]}}};
   endfunction

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(CTRL_OFS, 32'hf);
      chk(32'(oe_n), 32'h1);
      chk(32'(ps_o), 32'h1);
      rd_chk(4'h2, 32'h0);
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, CTRL_OFS, 32'(p));
         sample(5'h12, 6'h25);
         chk(32'(word), 32'(coded(5'h12, 6'h25, 2'(p))));
         chk(32'(capt), 32'(coded(5'h12, 6'h25, 2'(p))));
      end
      sample(5'h00, 6'h00);
      rd_chk(RES_OFS, 32'h0);
      sample(5'h1f, 6'h3f);
      rd_chk(RES_OFS, 32'h3ff);
      coarse <= 5'h01;
      @(posedge clk);
      fine   <= 6'h10;
      repeat (3) @(posedge clk);
      chk(32'(word), 32'h3ff);
      @(posedge clk);
      chk(32'(word), 32'h020);
      // flags under the inverting code
      bus(1'b1, CTRL_OFS, 32'h0);
      bus(1'b1, MASK_OFS, 32'h1);
      above <= 1'b1;
      repeat (6) @(posedge clk);
      chk({under, over, irq}, 32'h3);
      above <= 1'b0;
      below <= 1'b1;
      repeat (6) @(posedge clk);
      chk({under, over}, 32'h2);
      below <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk(STAT_OFS, 32'h3);
      bus(1'b1, STAT_OFS, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      rd_chk(STAT_OFS, 32'h2);
      bus(1'b1, STAT_OFS, 32'h2);
      rd_chk(STAT_OFS, 32'h0);
      // three-state, then power save with enable raised together
      bus(1'b1, CTRL_OFS, 32'h4);
      repeat (2) @(posedge clk);
      chk({ps_o, oe_n}, 32'h1);
      bus(1'b1, CTRL_OFS, 32'hc);
      sample(5'h1a, 6'h05);
      chk(32'(ps_o), 32'h1);
      rd_chk(RES_OFS, 32'h1020);
      chk(32'(word), 32'(coded(5'h01, 6'h10, 2'b00)));
      test_done();
   end

   initial begin
      #2000000;
      err_total++;
      $display("MISMATCH %0t run limit reached", $time);
      test_done();
   end
endmodule
